// ### rtl/srw_regs.svh
// command codes, pattern values and reset values of the reset/wake logic
`ifndef SRW_REGS_SVH
`define SRW_REGS_SVH

// serial commands
`define SRW_CMD_RST_EN 8'h66
`define SRW_CMD_RST 8'h99
`define SRW_CMD_WAKE 8'hab
`define SRW_CMD_ULTRA_DEEP_POWER_DOWN 8'h79
`define SRW_CMD_ULTRA_DEEP_POWER_DOWN_ALT 8'hb9
`define SRW_CMD_DPD 8'hb9

// pin-level reset pattern: four frames, first sample in the msb
`define SRW_JED_PATTERN 4'h5
`define SRW_JED_LAST 2'h3

// bits in one command byte
`define SRW_CMD_BITS 4'h8

// reset values
`define SRW_VOL_RESET 4'h0
`define SRW_PIN_RESET 3'h4

`endif

// ### rtl/srw_pkg.sv
// types shared by the reset/wake logic
package srw_pkg;

    // power state of the device
    typedef enum logic [1:0] {
        PWR_ACTIVE = 2'b00,
        PWR_DPD = 2'b01,
        PWR_ULTRA_DEEP_POWER_DOWN = 2'b10
    } srw_pwr_t;

    // kind of a finished chip-select frame
    typedef enum logic [1:0] {
        FRM_JED = 2'b00,
        FRM_CMD = 2'b01,
        FRM_SHORT = 2'b10
    } srw_frm_t;

    // source of the last internal reset
    typedef enum logic [2:0] {
        CAUSE_NONE = 3'b000,
        CAUSE_POR = 3'b001,
        CAUSE_HWPIN = 3'b010,
        CAUSE_JED = 3'b011,
        CAUSE_SW = 3'b100,
        CAUSE_WAKE = 3'b101
    } srw_cause_t;

    // serial interface width
    typedef enum logic [1:0] {
        WIDE_SPI = 2'b00,
        WIDE_DUAL = 2'b01,
        WIDE_QUAD = 2'b10
    } srw_wide_t;

endpackage

// ### rtl/srw_link_if.sv
// frame hand-over between the pin front end and the core logic
interface srw_link_if;
    import srw_pkg::*;

    logic req_tgl;
    logic ack_tgl;
    srw_frm_t kind;
    logic [7:0] data;

    modport link (output req_tgl, output kind, output data, input ack_tgl);
    modport core (input req_tgl, input kind, input data, output ack_tgl);
endinterface

// ### rtl/srw_link.sv
// pin front end: samples cs, sck and si and reports each frame that ends while no earlier report is pending
`include "srw_regs.svh"

module srw_link
    import srw_pkg::*;
(
    // link clock and reset
    input wire logic link_clk_i,
    input wire logic rstn_i,
    // serial pins
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    // frame hand-over
    srw_link_if.link lk
);

    // idle pin levels: deselected, clock low, data low
    localparam logic [2:0] PIN_RST = `SRW_PIN_RESET;

    logic [2:0] meta_reg;
    logic [2:0] sync_reg;
    logic [1:0] prev_reg;
    logic ack_meta_reg;
    logic ack_sync_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic sck_seen_reg;
    logic req_reg;
    srw_frm_t kind_reg;
    logic [7:0] data_reg;
    logic cs_s;
    logic sck_s;
    logic si_s;
    logic cs_rise;
    logic sck_edge;
    logic sck_rise;
    logic busy;
    logic clocked;

    // two flops on every pin before anything looks at it
    always_ff @(posedge link_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_reg <= PIN_RST;
            sync_reg <= PIN_RST;
            prev_reg <= PIN_RST[2:1];
        end else begin
            meta_reg <= {cs_n_i, sck_i, si_i};
            sync_reg <= meta_reg;
            prev_reg <= sync_reg[2:1];
        end
    end

    // acknowledge toggle back from the core clock
    always_ff @(posedge link_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_meta_reg <= 1'b0;
            ack_sync_reg <= 1'b0;
        end else begin
            ack_meta_reg <= lk.ack_tgl;
            ack_sync_reg <= ack_meta_reg;
        end
    end

    assign cs_s = sync_reg[2];
    assign sck_s = sync_reg[1];
    assign si_s = sync_reg[0];
    assign cs_rise = cs_s & ~prev_reg[1];
    assign sck_edge = sck_s ^ prev_reg[0];
    assign sck_rise = sck_s & ~prev_reg[0];
    assign busy = req_reg != ack_sync_reg;
    // any sck edge since the last frame end marks the frame clocked
    assign clocked = sck_seen_reg | sck_edge;

    // command byte shifter, rising sck serves mode 0 and mode 3
    always_ff @(posedge link_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
        end else if (cs_rise) begin
            bit_cnt_reg <= 4'h0;
        end else if (sck_rise && !cs_s && bit_cnt_reg != `SRW_CMD_BITS) begin
            shift_reg <= {shift_reg[6:0], si_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
    end

    // sck activity, also between frames, spoils the pin pattern
    always_ff @(posedge link_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sck_seen_reg <= 1'b0;
        end else if (cs_rise) begin
            sck_seen_reg <= 1'b0;
        end else if (sck_edge) begin
            sck_seen_reg <= 1'b1;
        end
    end

    // frame report held until acknowledged; a frame ending while the
    // previous one is still in flight is dropped
    always_ff @(posedge link_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            req_reg <= 1'b0;
            kind_reg <= FRM_SHORT;
            data_reg <= 8'h00;
        end else if (cs_rise && !busy) begin
            req_reg <= ~req_reg;
            if (!clocked) begin
                kind_reg <= FRM_JED;
                data_reg <= {7'h00, si_s}; // RULE6
            end else if (bit_cnt_reg == `SRW_CMD_BITS) begin
                kind_reg <= FRM_CMD;
                data_reg <= shift_reg;
            end else begin
                kind_reg <= FRM_SHORT;
                data_reg <= shift_reg;
            end
        end
    end

    assign lk.req_tgl = req_reg;
    assign lk.kind = kind_reg;
    assign lk.data = data_reg;

    a_si_sample: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
        cs_rise && !busy && !clocked |=> data_reg[0] == $past(si_s)) // RULE6
        else $error("si not sampled at cs rise");

endmodule

// ### rtl/srw_top.sv
// reset and wake logic of a serial flash: pin pattern, wake, soft reset
//
// Overview of operation
// [RULE1] pin pattern wakes from both power-down modes
// [RULE2] pin pattern returns device to power-on state
// [RULE3] host holds sck idle throughout pattern
// [RULE4] reset only on 0101 at cs rises
// [RULE5] host sets si with cs fall, alternating
// [RULE6] si sampled at every cs rising edge; code samples it only at the end of clockless frames
// [RULE7] device never drives si during frame
// [RULE8] fourth frame matching 5h starts reset
// [RULE9] any sck activity aborts the pattern
// [RULE10] pin reset forces single-line serial mode
// [RULE11] wake command in ultra-deep resets, goes idle
// [RULE12] buffer undefined after wake command
// [RULE13] por, pin pattern, reset pin exit ultra-deep
// [RULE14] buffer undefined after those three exits
// [RULE15] soft reset ends all work, power-on state
// [RULE16] soft reset clears all volatile settings
// [RULE17] soft reset needs enable then reset command
// [RULE18] other command after enable cancels it
// [RULE19] entry command puts device in ultra-deep
// [RULE20] wrong sample restarts pattern from frame one
// [RULE21] every reset clears enable and detector
`include "srw_regs.svh"

module srw_top
    import srw_pkg::*;
#(
    parameter logic ULTRA_DEEP_POWER_DOWN_ALT_EN = 1'b0,
    parameter logic [7:0] DPD_CMD = `SRW_CMD_DPD
) (
    // clocks and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic link_clk_i,
    // serial pins
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    output logic si_o,
    output logic si_oe_o,
    // hardware reset pin
    input wire logic hw_reset_n_i,
    // settings from the device core
    input wire logic [3:0] vol_set_i,
    input wire logic [3:0] vol_clr_i,
    input wire logic wide_load_i,
    input wire logic [1:0] wide_mode_i,
    input wire logic buf_init_i,
    // power and setting status
    output logic deep_power_down_o,
    output logic ultra_deep_power_down_o,
    output logic reset_enable_o,
    output logic write_enable_latch_o,
    output logic vol_status_o,
    output logic suspend_o,
    output logic cont_read_o,
    output logic [1:0] wide_mode_o,
    output logic buf_undefined_o,
    // internal reset
    output logic core_reset_o,
    output logic [2:0] reset_cause_o
);

    localparam logic [3:0] VOL_RST = `SRW_VOL_RESET;

    srw_link_if lk_if();

    logic hw_meta_reg;
    logic hw_sync_reg;
    logic hw_prev_reg;
    logic req_meta_reg;
    logic req_sync_reg;
    logic ack_reg;
    logic por_pend_reg;
    logic [1:0] jed_cnt_reg;
    logic [3:0] jed_pat_reg;
    logic rst_en_reg;
    srw_pwr_t pwr_reg;
    logic [3:0] vol_reg;
    srw_wide_t wide_reg;
    logic buf_undef_reg;
    logic core_rst_reg;
    srw_cause_t cause_reg;
    logic si_reg;
    logic si_oe_reg;

    logic hw_low;
    logic hw_fire;
    logic frm_new;
    logic cmd_new;
    logic cmd_act;
    logic jed_new;
    logic [7:0] cmd;
    logic si_smp;
    logic jed_fire;
    logic sw_fire;
    logic wake_fire;
    logic dpd_release;
    logic any_reset;
    logic clr_all;
    srw_cause_t cause;

    // entry to ultra-deep, with the alternate code when enabled
    function automatic logic ultra_deep_power_down_entry(input logic [7:0] c);
        ultra_deep_power_down_entry = (c == `SRW_CMD_ULTRA_DEEP_POWER_DOWN) ||
            (ULTRA_DEEP_POWER_DOWN_ALT_EN && c == `SRW_CMD_ULTRA_DEEP_POWER_DOWN_ALT);
    endfunction

    // pin front end on the link clock
    srw_link u_link (
        .link_clk_i(link_clk_i),
        .rstn_i(rstn_i),
        .cs_n_i(cs_n_i),
        .sck_i(sck_i),
        .si_i(si_i),
        .lk(lk_if)
    );

    // reset pin is asynchronous to us, two flops first
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hw_meta_reg <= 1'b1;
            hw_sync_reg <= 1'b1;
            hw_prev_reg <= 1'b1;
        end else begin
            hw_meta_reg <= hw_reset_n_i;
            hw_sync_reg <= hw_meta_reg;
            hw_prev_reg <= hw_sync_reg;
        end
    end

    // request toggle crossing; frame data is stable until we acknowledge
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            req_meta_reg <= 1'b0;
            req_sync_reg <= 1'b0;
            ack_reg <= 1'b0;
        end else begin
            req_meta_reg <= lk_if.req_tgl;
            req_sync_reg <= req_meta_reg;
            ack_reg <= req_sync_reg;
        end
    end

    assign lk_if.ack_tgl = ack_reg;

    // power-on reset reported once after release
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            por_pend_reg <= 1'b1;
        end else begin
            por_pend_reg <= 1'b0;
        end
    end

    // event decode; frames are ignored while the reset pin is held
    always_comb begin
        hw_low = ~hw_sync_reg;
        hw_fire = ~hw_sync_reg & hw_prev_reg; // RULE13
        frm_new = req_sync_reg ^ ack_reg;
        cmd = lk_if.data;
        si_smp = lk_if.data[0];
        cmd_new = frm_new && lk_if.kind == FRM_CMD && !hw_low;
        jed_new = frm_new && lk_if.kind == FRM_JED && !hw_low;
        cmd_act = cmd_new && pwr_reg == PWR_ACTIVE;
        jed_fire = jed_new && jed_cnt_reg == `SRW_JED_LAST &&
            {jed_pat_reg[2:0], si_smp} == `SRW_JED_PATTERN; // RULE4 RULE8
        sw_fire = cmd_act && rst_en_reg && cmd == `SRW_CMD_RST; // RULE17
        wake_fire = cmd_new && pwr_reg == PWR_ULTRA_DEEP_POWER_DOWN &&
            cmd == `SRW_CMD_WAKE; // RULE11
        dpd_release = cmd_new && pwr_reg == PWR_DPD &&
            cmd == `SRW_CMD_WAKE;
        any_reset = por_pend_reg | hw_fire | jed_fire | sw_fire | wake_fire;
        clr_all = any_reset | hw_low;
    end

    // reset source, strongest first
    always_comb begin
        if (por_pend_reg) begin
            cause = CAUSE_POR;
        end else if (hw_fire) begin
            cause = CAUSE_HWPIN;
        end else if (jed_fire) begin
            cause = CAUSE_JED;
        end else if (sw_fire) begin
            cause = CAUSE_SW;
        end else if (wake_fire) begin
            cause = CAUSE_WAKE;
        end else begin
            cause = CAUSE_NONE;
        end
    end

    // pin pattern detector, progress counted in frames
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            jed_cnt_reg <= 2'h0;
            jed_pat_reg <= 4'h0;
        end else if (any_reset) begin
            jed_cnt_reg <= 2'h0; // RULE21
            jed_pat_reg <= 4'h0;
        end else if (frm_new && lk_if.kind != FRM_JED) begin
            jed_cnt_reg <= 2'h0; // RULE9
            jed_pat_reg <= 4'h0;
        end else if (jed_new) begin
            if (si_smp == jed_cnt_reg[0]) begin
                jed_cnt_reg <= jed_cnt_reg + 2'h1;
                jed_pat_reg <= {jed_pat_reg[2:0], si_smp};
            end else begin
                // a stray low may itself be a first frame
                jed_cnt_reg <= si_smp ? 2'h0 : 2'h1; // RULE20
                jed_pat_reg <= {3'h0, si_smp};
            end
        end
    end

    // reset enable: set by the enable command, any other one drops it
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_en_reg <= 1'b0;
        end else if (clr_all) begin
            rst_en_reg <= 1'b0; // RULE21
        end else if (cmd_act) begin
            rst_en_reg <= cmd == `SRW_CMD_RST_EN; // RULE17 RULE18
        end
    end

    // power state; every reset lands in active
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pwr_reg <= PWR_ACTIVE;
        end else if (clr_all) begin
            pwr_reg <= PWR_ACTIVE; // RULE1 RULE2 RULE11 RULE13
        end else begin
            unique case (pwr_reg)
                PWR_ACTIVE: begin
                    if (cmd_new && ultra_deep_power_down_entry(cmd)) begin
                        pwr_reg <= PWR_ULTRA_DEEP_POWER_DOWN; // RULE19
                    end else if (cmd_new && cmd == DPD_CMD) begin
                        pwr_reg <= PWR_DPD;
                    end
                end
                PWR_DPD: begin
                    if (dpd_release) begin
                        pwr_reg <= PWR_ACTIVE;
                    end
                end
                PWR_ULTRA_DEEP_POWER_DOWN: begin
                    pwr_reg <= PWR_ULTRA_DEEP_POWER_DOWN;
                end
                default: begin
                    pwr_reg <= PWR_ACTIVE;
                end
            endcase
        end
    end

    // volatile settings; a reset beats a set in the same cycle
    for (genvar i = 0; i < 4; i++) begin : g_vol
        always_ff @(posedge clock_i or negedge rstn_i) begin
            if (!rstn_i) begin
                vol_reg[i] <= VOL_RST[i];
            end else if (clr_all) begin
                vol_reg[i] <= VOL_RST[i]; // RULE15 RULE16
            end else if (vol_set_i[i]) begin
                vol_reg[i] <= 1'b1;
            end else if (vol_clr_i[i]) begin
                vol_reg[i] <= 1'b0;
            end
        end
    end

    // interface width; wide modes only change while active
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wide_reg <= WIDE_SPI;
        end else if (clr_all) begin
            wide_reg <= WIDE_SPI; // RULE10
        end else if (wide_load_i && pwr_reg == PWR_ACTIVE) begin
            wide_reg <= srw_wide_t'(wide_mode_i);
        end
    end

    // buffer contents lost on leaving ultra-deep or at power-on;
    // the set wins over a clear in the same cycle
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            buf_undef_reg <= 1'b1;
        end else if (any_reset &&
                (pwr_reg == PWR_ULTRA_DEEP_POWER_DOWN || por_pend_reg)) begin
            buf_undef_reg <= 1'b1; // RULE12 RULE14
        end else if (buf_init_i) begin
            buf_undef_reg <= 1'b0;
        end
    end

    // internal reset pulse and its source
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            core_rst_reg <= 1'b0;
            cause_reg <= CAUSE_NONE;
        end else begin
            core_rst_reg <= any_reset; // RULE2 RULE15
            if (any_reset) begin
                cause_reg <= cause;
            end
        end
    end

    // si is an input here; wide-mode output data lives elsewhere
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            si_reg <= 1'b0;
            si_oe_reg <= 1'b0;
        end else begin
            si_reg <= 1'b0;
            si_oe_reg <= 1'b0; // RULE7
        end
    end

    // outputs, all taken from flops
    assign si_o = si_reg;
    assign si_oe_o = si_oe_reg;
    assign deep_power_down_o = pwr_reg == PWR_DPD;
    assign ultra_deep_power_down_o = pwr_reg == PWR_ULTRA_DEEP_POWER_DOWN;
    assign reset_enable_o = rst_en_reg;
    assign write_enable_latch_o = vol_reg[0];
    assign vol_status_o = vol_reg[1];
    assign suspend_o = vol_reg[2];
    assign cont_read_o = vol_reg[3];
    assign wide_mode_o = wide_reg;
    assign buf_undefined_o = buf_undef_reg;
    assign core_reset_o = core_rst_reg;
    assign reset_cause_o = cause_reg;

    // checks kept next to the logic

    a_jed_reset: assert property (@(posedge clock_i) disable iff (!rstn_i)
        jed_fire && !por_pend_reg && !hw_fire |=>
        core_rst_reg && cause_reg == CAUSE_JED) // RULE8
        else $error("pin pattern gave no reset");

    a_jed_wakes: assert property (@(posedge clock_i) disable iff (!rstn_i)
        jed_new && pwr_reg != PWR_ACTIVE && jed_fire |=>
        pwr_reg == PWR_ACTIVE) // RULE1
        else $error("pin pattern did not wake");

    a_spi_after: assert property (@(posedge clock_i) disable iff (!rstn_i)
        any_reset |=> wide_reg == WIDE_SPI && vol_reg == VOL_RST) // RULE10
        else $error("reset left wide mode or settings");

    a_wake_cmd: assert property (@(posedge clock_i) disable iff (!rstn_i)
        wake_fire |=> core_rst_reg && pwr_reg == PWR_ACTIVE &&
        buf_undef_reg) // RULE11
        else $error("wake command mishandled");

    a_abort_pat: assert property (@(posedge clock_i) disable iff (!rstn_i)
        frm_new && lk_if.kind != FRM_JED |=>
        jed_cnt_reg == 2'h0 ##1 !jed_fire) // RULE9
        else $error("clocked frame kept pattern");

    a_pair_need: assert property (@(posedge clock_i) disable iff (!rstn_i)
        core_rst_reg && cause_reg == CAUSE_SW |->
        $past(rst_en_reg) && !rst_en_reg) // RULE17
        else $error("soft reset without enable");

    a_other_drop: assert property (@(posedge clock_i) disable iff (!rstn_i)
        cmd_act && cmd != `SRW_CMD_RST_EN |=> !rst_en_reg) // RULE18
        else $error("enable kept after other command");

    a_ultra_deep_power_down_entry: assert property (@(posedge clock_i) disable iff (!rstn_i)
        pwr_reg == PWR_ACTIVE && cmd_new && ultra_deep_power_down_entry(cmd) &&
        !any_reset |=> pwr_reg == PWR_ULTRA_DEEP_POWER_DOWN) // RULE19
        else $error("no ultra-deep entry");

    a_pin_exit: assert property (@(posedge clock_i) disable iff (!rstn_i)
        hw_fire && pwr_reg == PWR_ULTRA_DEEP_POWER_DOWN |=>
        pwr_reg == PWR_ACTIVE && buf_undef_reg) // RULE13
        else $error("reset pin did not exit ultra-deep");

    a_restart: assert property (@(posedge clock_i) disable iff (!rstn_i)
        jed_new && !any_reset && si_smp != jed_cnt_reg[0] |=>
        jed_cnt_reg == {1'b0, ~$past(si_smp)}) // RULE20
        else $error("mismatch did not restart pattern");

    a_det_clear: assert property (@(posedge clock_i) disable iff (!rstn_i)
        any_reset |=> jed_cnt_reg == 2'h0 && !rst_en_reg) // RULE21
        else $error("reset left detector or enable");

    a_si_undrv: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !si_oe_reg) // RULE7
        else $error("si driven");

endmodule

// ### bench/srw_host.sv
// host controller model driving the serial pins of the flash
module srw_host (
    // link clock
    input wire logic link_clk_i,
    // serial pins
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // pins idle: deselected, clock low
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge link_clk_i);
    endtask

    // released si flips so a stale level is never mistaken for data
    task automatic gap;
        tick(4);
        si_o <= ~si_o;
        tick(56);
    endtask

    // clockless frame, si set together with the select
    task automatic pin(input logic b);
        @(posedge link_clk_i);
        cs_n_o <= 1'b0;
        si_o <= b;
        tick(10);
        cs_n_o <= 1'b1;
        gap();
    endtask

    // n clockless frames, first sample in the msb
    task automatic pins(input logic [7:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            pin(v[i]);
        end
    endtask

    // command frame of n bits, msb first, sampled on sck rise
    task automatic cmd(input logic [7:0] b, input int n);
        @(posedge link_clk_i);
        cs_n_o <= 1'b0;
        for (int i = 0; i < n; i++) begin
            si_o <= b[7-i];
            tick(2);
            sck_o <= 1'b1;
            tick(2);
            sck_o <= 1'b0;
        end
        tick(2);
        cs_n_o <= 1'b1;
        gap();
    endtask

    // stray clock pulse while deselected
    task automatic blip;
        @(posedge link_clk_i);
        sck_o <= 1'b1;
        tick(2);
        sck_o <= 1'b0;
        tick(2);
    endtask
endmodule

// ### bench/tb_top.sv
// self-checking bench of the reset and wake logic
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock_i = 1'b0, link_clk_i = 1'b0, rstn_i = 1'b0;
    logic hw_reset_n_i = 1'b1, wide_load_i = 1'b0, buf_init_i = 1'b0;
    logic [3:0] vol_set_i = 4'h0, vol_clr_i = 4'h0;
    logic [1:0] wide_mode_i = 2'h0;
    logic cs_n, sck, si, si_o, si_oe_o, deep_power_down, ultra_deep_power_down, ren;
    logic write_enable_latch, vst, sus, crd, bu, core_reset_o;
    logic [1:0] wide_mode_o;
    logic [2:0] reset_cause_o;
    int n_errors = 0, compares = 0, pulses = 0, p0 = 0;
    logic [3:0] v;
    logic [7:0] x;

    // core clock 40 ns, link clock 6 ns with an odd offset
    initial forever #20 clock_i = ~clock_i;
    initial begin
        #1.7;
        forever #3 link_clk_i = ~link_clk_i;
    end

    srw_host host (.link_clk_i(link_clk_i), .cs_n_o(cs_n), .sck_o(sck),
        .si_o(si));

    srw_top dut (.clock_i(clock_i), .rstn_i(rstn_i),
        .link_clk_i(link_clk_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
        .si_o(si_o), .si_oe_o(si_oe_o), .hw_reset_n_i(hw_reset_n_i),
        .vol_set_i(vol_set_i), .vol_clr_i(vol_clr_i),
        .wide_load_i(wide_load_i), .wide_mode_i(wide_mode_i),
        .buf_init_i(buf_init_i), .deep_power_down_o(deep_power_down),
        .ultra_deep_power_down_o(ultra_deep_power_down), .reset_enable_o(ren),
        .write_enable_latch_o(write_enable_latch), .vol_status_o(vst), .suspend_o(sus),
        .cont_read_o(crd), .wide_mode_o(wide_mode_o),
        .buf_undefined_o(bu), .core_reset_o(core_reset_o),
        .reset_cause_o(reset_cause_o));

    task automatic complete_run;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // expected status byte: undefined, ultra, deep, enable, volatile
    function automatic logic [7:0] st(input logic b, input logic u,
        input logic d, input logic r, input logic [3:0] vv);
        return {b, u, d, r, vv};
    endfunction

    // one-cycle reset pulses are counted, never sampled late
    always @(posedge clock_i) if (core_reset_o === 1'b1) pulses++;

    // si must stay undriven inside any frame
    always @(posedge clock_i) if (cs_n === 1'b0)
        check({6'h0, si_oe_o, si_o}, 8'h00);

    // settle, then compare status, width, cause and new pulses
    task automatic expect_st(input string nm, input logic [7:0] s,
        input logic [1:0] w, input logic [2:0] c, input int p);
        repeat (12) @(posedge clock_i);
        check({bu, ultra_deep_power_down, deep_power_down, ren, crd, sus, vst, write_enable_latch}, s);
        check({wide_mode_o, reset_cause_o, 3'(pulses-p0)}, {w, c, 3'(p)});
        p0 = pulses;
        $display("test %s done", nm);
    endtask

    // load volatile bits and width; clear of the rest loses to set
    task automatic setup(input logic [3:0] sv, input logic [1:0] w);
        @(posedge clock_i);
        vol_set_i <= sv;
        vol_clr_i <= 4'hf;
        wide_load_i <= 1'b1;
        wide_mode_i <= w;
        buf_init_i <= 1'b1;
        @(posedge clock_i);
        vol_set_i <= 4'h0;
        vol_clr_i <= 4'h0;
        wide_load_i <= 1'b0;
        buf_init_i <= 1'b0;
    endtask

    task automatic hw_pulse;
        @(posedge clock_i);
        hw_reset_n_i <= 1'b0;
        repeat (6) @(posedge clock_i);
        hw_reset_n_i <= 1'b1;
    endtask

    // hang guard
    initial begin
        repeat (60000) @(posedge clock_i);
        n_errors++;
        complete_run();
    end

    initial begin
        void'($urandom(32'hda51));
        repeat (8) @(posedge clock_i);
        rstn_i <= 1'b1;
        expect_st("por", st(1, 0, 0, 0, 0), 2'h0, 3'h1, 1);
        v = 4'($urandom_range(15, 1));
        setup(v, 2'h1);
        do x = 8'($urandom); while (x inside {8'h66, 8'h99, 8'h79,
            8'hb9, 8'hab});
        host.cmd(8'h66, 8);
        host.cmd(x, 8);
        host.cmd(8'h99, 8);
        expect_st("cancel", st(0, 0, 0, 0, v), 2'h1, 3'h1, 0);
        setup(v, 2'h2);
        host.cmd(8'h66, 8);
        expect_st("enable", st(0, 0, 0, 1, v), 2'h2, 3'h1, 0);
        host.cmd(8'h99, 8);
        expect_st("soft", st(0, 0, 0, 0, 0), 2'h0, 3'h4, 1);
        host.cmd(8'h79, 8);
        expect_st("ultra_deep_power_down", st(0, 1, 0, 0, 0), 2'h0, 3'h4, 0);
        host.cmd(8'hab, 8);
        expect_st("wake", st(1, 0, 0, 0, 0), 2'h0, 3'h5, 1);
        setup(v, 2'h2);
        host.cmd(8'h79, 8);
        host.pins(8'h05, 4);
        expect_st("pin_u", st(1, 0, 0, 0, 0), 2'h0, 3'h3, 1);
        setup(4'h0, 2'h0);
        host.cmd(8'hb9, 8);
        expect_st("dpd", st(0, 0, 1, 0, 0), 2'h0, 3'h3, 0);
        host.pins(8'h05, 4);
        expect_st("pin_d", st(0, 0, 0, 0, 0), 2'h0, 3'h3, 1);
        host.pins(8'h01, 2);
        host.blip();
        host.pins(8'h01, 2);
        host.cmd(8'h00, 3);
        expect_st("abort", st(0, 0, 0, 0, 0), 2'h0, 3'h3, 0);
        host.pins(8'h06, 4);
        host.cmd(8'h00, 3);
        expect_st("bad", st(0, 0, 0, 0, 0), 2'h0, 3'h3, 0);
        host.pins(8'h05, 5);
        expect_st("restart", st(0, 0, 0, 0, 0), 2'h0, 3'h3, 1);
        setup(v, 2'h1);
        host.cmd(8'h66, 8);
        hw_pulse();
        expect_st("hw", st(0, 0, 0, 0, 0), 2'h0, 3'h2, 1);
        host.cmd(8'h79, 8);
        hw_pulse();
        expect_st("hw_u", st(1, 0, 0, 0, 0), 2'h0, 3'h2, 1);
        complete_run();
    end
endmodule
